// ==== pie_pkg.sv ====
// Package for the peripheral interrupt enable bank: map, fields, types
package pie_pkg;

   // ==========================================================
   // Bus and register map
   localparam int          PIE_ADDR_W     = 8;
   localparam logic [7:0]  PIE_OFF_CTRL   = 8'h00;
   localparam logic [7:0]  PIE_OFF_EN2    = 8'h04;
   localparam logic [7:0]  PIE_OFF_EN3    = 8'h08;
   localparam logic [7:0]  PIE_OFF_EN4    = 8'h0c;
   localparam logic [7:0]  PIE_OFF_FLAG2  = 8'h10;
   localparam logic [7:0]  PIE_OFF_FLAG3  = 8'h14;
   localparam logic [7:0]  PIE_OFF_FLAG4  = 8'h18;
   localparam logic [7:0]  PIE_OFF_STAT   = 8'h1c;

   // ==========================================================
   // Field positions and reset values
   localparam int          PIE_GLOBAL_BIT = 7;
   localparam int          PIE_GATE_BIT   = 6;
   localparam int          PIE_STAT_REQ   = 0;
   localparam logic [7:0]  PIE_EN_RST     = 8'h00;
   localparam logic [7:0]  PIE_FLAG_RST   = 8'h00;
   localparam logic [1:0]  PIE_CTRL_RST   = 2'h0;
   localparam logic [1:0]  PIE_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  PIE_RESP_SLV   = 2'h2;

   // ==========================================================
   // Types
   typedef struct packed {
      logic timer6_match_irq_en;
      logic comparator2_irq_en;
      logic comparator1_irq_en;
      logic nonvolatile_done_irq_en;
      logic serial_port2_irq_en;
      logic serial_port2_collision_irq_en;
      logic timer4_match_irq_en;
      logic num_ctrl_osc_rollover_irq_en;
   } pie_en2_t;

   typedef struct packed {
      logic oscillator_fail_irq_en;
      logic clock_switch_done_irq_en;
      logic timer3_gate_irq_en;
      logic timer3_overflow_irq_en;
      logic logic_cell4_irq_en;
      logic logic_cell3_irq_en;
      logic logic_cell2_irq_en;
      logic logic_cell1_irq_en;
   } pie_en3_t;

   typedef struct packed {
      logic waveform_gen2_irq_en;
      logic waveform_gen1_irq_en;
      logic timer5_gate_irq_en;
      logic timer5_overflow_irq_en;
      logic capture_unit4_irq_en;
      logic capture_unit3_irq_en;
      logic capture_unit2_irq_en;
      logic capture_unit1_irq_en;
   } pie_en4_t;

   // Source events, one byte per group, same bit order as the enables
   typedef struct packed {
      logic [7:0] grp2;
      logic [7:0] grp3;
      logic [7:0] grp4;
   } pie_events_t;

   typedef enum logic [3:0] {
      SEL_CTRL  = 4'b0000,
      SEL_EN2   = 4'b0001,
      SEL_EN3   = 4'b0010,
      SEL_EN4   = 4'b0011,
      SEL_FLAG2 = 4'b0100,
      SEL_FLAG3 = 4'b0101,
      SEL_FLAG4 = 4'b0110,
      SEL_STAT  = 4'b0111,
      SEL_NONE  = 4'b1000
   } pie_sel_t;

endpackage : pie_pkg

// ==== pie_flag_group.sv ====
// Sticky request flags of one source group, software writable
module pie_flag_group
   import pie_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Source events
   input  wire logic [WIDTH-1:0] event_in,
   // Software write
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // Flag state
   output logic      [WIDTH-1:0] flags
);

   // ==========================================================
   // Flag storage
   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   // Set wins over a clearing write in the same cycle
   always_comb
   begin
      flags_next = wr_en ? wr_data : flags_reg;
      flags_next = flags_next | event_in;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_reg <= WIDTH'(PIE_FLAG_RST);
      else
         flags_reg <= flags_next;
   end

   assign flags = flags_reg;

endmodule : pie_flag_group

// ==== pie_enable_bank.sv ====
// Peripheral interrupt enable bank with AXI4-Lite register access
//
// Behaviour
// RULE1 - Enable2 bit 7 gates timer 6 match
// RULE2 - Enable2 bit 6 gates comparator 2
// RULE3 - Enable2 bit 5 gates comparator 1
// RULE4 - Enable2 bit 4 gates nonvolatile task done
// RULE5 - Enable2 bit 3 gates serial port 2
// RULE6 - Enable2 bit 2 gates serial port 2 collision
// RULE7 - Enable2 bit 1 gates timer 4 match
// RULE8 - Enable2 bit 0 gates oscillator rollover
// RULE9 - Enable3 bit 7 gates oscillator failure
// RULE10 - Enable3 bit 6 gates clock switch done
// RULE11 - Enable3 bit 5 gates timer 3 gate
// RULE12 - Enable3 bit 4 gates timer 3 overflow
// RULE13 - Enable3 bits 3..0 gate logic cells 4..1
// RULE14 - Enable4 bits 7,6 gate waveform generators 2,1
// RULE15 - Enable4 bit 5 gates timer 5 gate
// RULE16 - Enable4 bit 4 gates timer 5 overflow
// RULE17 - Enable4 bits 3..0 gate capture units 4..1
// RULE18 - All enable bits read/write, reset to zero
// RULE19 - Flags set regardless of any enable
// RULE20 - Peripheral gate blocks all peripheral requests
// RULE21 - Global enable blocks all interrupts
// RULE22 - Request is OR of flag-and-enable, gated
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
module pie_enable_bank
   import pie_pkg::*;
#(
   parameter int ADDR_W = PIE_ADDR_W
)
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Peripheral source events
   input  wire pie_events_t       src_events,
   // Request to the core
   output logic                   periph_irq_req
);

   // ==========================================================
   // Address decode
   function automatic pie_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr);
      if (a == PIE_OFF_CTRL)
         decode_addr = SEL_CTRL;
      else if (a == PIE_OFF_EN2)
         decode_addr = SEL_EN2;
      else if (a == PIE_OFF_EN3)
         decode_addr = SEL_EN3;
      else if (a == PIE_OFF_EN4)
         decode_addr = SEL_EN4;
      else if (a == PIE_OFF_FLAG2)
         decode_addr = SEL_FLAG2;
      else if (a == PIE_OFF_FLAG3)
         decode_addr = SEL_FLAG3;
      else if (a == PIE_OFF_FLAG4)
         decode_addr = SEL_FLAG4;
      else if (a == PIE_OFF_STAT)
         decode_addr = SEL_STAT;
      else
         decode_addr = SEL_NONE;
   endfunction : decode_addr

   // ==========================================================
   // Write channel capture
   logic              aw_full_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic              w_full_reg;
   logic [7:0]        wdata_reg;
   logic              wstrb0_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              wr_go;
   pie_sel_t          wr_sel;
   logic              wr_byte;

   // No new address or data while a response is still owed
   assign s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready  = !w_full_reg && !bvalid_reg;
   assign wr_go         = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_sel        = decode_addr(awaddr_reg);
   assign wr_byte       = wr_go && wstrb0_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         awaddr_reg  <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_full_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full_reg <= 1'b0;
         wdata_reg  <= 8'h00;
         wstrb0_reg <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata[7:0];
         wstrb0_reg <= s_axi_wstrb[0];
      end
      else if (wr_go)
         w_full_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= PIE_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= (wr_sel == SEL_NONE) ? PIE_RESP_SLV : PIE_RESP_OKAY;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // ==========================================================
   // Control and enable registers
   logic     global_en_reg;
   logic     periph_gate_reg;
   pie_en2_t en2_reg;
   pie_en3_t en3_reg;
   pie_en4_t en4_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_en_reg   <= PIE_CTRL_RST[1];
         periph_gate_reg <= PIE_CTRL_RST[0];
      end
      else if (wr_byte && wr_sel == SEL_CTRL)
      begin
         global_en_reg   <= wdata_reg[PIE_GLOBAL_BIT];
         periph_gate_reg <= wdata_reg[PIE_GATE_BIT];
      end
   end

   // Every reset flavour lands on the same synchronous clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en2_reg <= pie_en2_t'(PIE_EN_RST); // RULE18
         en3_reg <= pie_en3_t'(PIE_EN_RST); // RULE18
         en4_reg <= pie_en4_t'(PIE_EN_RST); // RULE18
      end
      else if (wr_byte)
      begin
         if (wr_sel == SEL_EN2)
            en2_reg <= pie_en2_t'(wdata_reg); // RULE18
         else if (wr_sel == SEL_EN3)
            en3_reg <= pie_en3_t'(wdata_reg); // RULE18
         else if (wr_sel == SEL_EN4)
            en4_reg <= pie_en4_t'(wdata_reg); // RULE18
      end
   end

   // ==========================================================
   // Request flags
   logic [7:0] ev_grp [3];
   logic [7:0] fl_grp [3];
   logic [2:0] fl_wr;

   assign ev_grp[0] = src_events.grp2;
   assign ev_grp[1] = src_events.grp3;
   assign ev_grp[2] = src_events.grp4;
   assign fl_wr[0]  = wr_byte && wr_sel == SEL_FLAG2;
   assign fl_wr[1]  = wr_byte && wr_sel == SEL_FLAG3;
   assign fl_wr[2]  = wr_byte && wr_sel == SEL_FLAG4;

   // Flags see the raw event, never the enables
   for (genvar g = 0; g < 3; g++)
   begin : g_flags
      pie_flag_group #(
         .WIDTH    (8)
      ) u_flags (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .event_in (ev_grp[g]), // RULE19
         .wr_en    (fl_wr[g]),
         .wr_data  (wdata_reg),
         .flags    (fl_grp[g])
      );
   end

   // ==========================================================
   // Per-source masking
   logic [7:0] pend2;
   logic [7:0] pend3;
   logic [7:0] pend4;

   assign pend2[7] = fl_grp[0][7] & en2_reg.timer6_match_irq_en; // RULE1
   assign pend2[6] = fl_grp[0][6] & en2_reg.comparator2_irq_en; // RULE2
   assign pend2[5] = fl_grp[0][5] & en2_reg.comparator1_irq_en; // RULE3
   assign pend2[4] = fl_grp[0][4] & en2_reg.nonvolatile_done_irq_en; // RULE4
   assign pend2[3] = fl_grp[0][3] & en2_reg.serial_port2_irq_en; // RULE5
   assign pend2[2] = fl_grp[0][2] & en2_reg.serial_port2_collision_irq_en; // RULE6
   assign pend2[1] = fl_grp[0][1] & en2_reg.timer4_match_irq_en; // RULE7
   assign pend2[0] = fl_grp[0][0] & en2_reg.num_ctrl_osc_rollover_irq_en; // RULE8

   assign pend3[7] = fl_grp[1][7] & en3_reg.oscillator_fail_irq_en; // RULE9
   assign pend3[6] = fl_grp[1][6] & en3_reg.clock_switch_done_irq_en; // RULE10
   assign pend3[5] = fl_grp[1][5] & en3_reg.timer3_gate_irq_en; // RULE11
   assign pend3[4] = fl_grp[1][4] & en3_reg.timer3_overflow_irq_en; // RULE12
   assign pend3[3] = fl_grp[1][3] & en3_reg.logic_cell4_irq_en; // RULE13
   assign pend3[2] = fl_grp[1][2] & en3_reg.logic_cell3_irq_en; // RULE13
   assign pend3[1] = fl_grp[1][1] & en3_reg.logic_cell2_irq_en; // RULE13
   assign pend3[0] = fl_grp[1][0] & en3_reg.logic_cell1_irq_en; // RULE13

   assign pend4[7] = fl_grp[2][7] & en4_reg.waveform_gen2_irq_en; // RULE14
   assign pend4[6] = fl_grp[2][6] & en4_reg.waveform_gen1_irq_en; // RULE14
   assign pend4[5] = fl_grp[2][5] & en4_reg.timer5_gate_irq_en; // RULE15
   assign pend4[4] = fl_grp[2][4] & en4_reg.timer5_overflow_irq_en; // RULE16
   assign pend4[3] = fl_grp[2][3] & en4_reg.capture_unit4_irq_en; // RULE17
   assign pend4[2] = fl_grp[2][2] & en4_reg.capture_unit3_irq_en; // RULE17
   assign pend4[1] = fl_grp[2][1] & en4_reg.capture_unit2_irq_en; // RULE17
   assign pend4[0] = fl_grp[2][0] & en4_reg.capture_unit1_irq_en; // RULE17

   // ==========================================================
   // Request to the core
   logic any_pend;
   logic irq_next;
   logic irq_reg;

   assign any_pend = |{pend2, pend3, pend4}; // RULE22
   // Registered so the core sees a glitch-free level, one cycle late
   assign irq_next = any_pend && periph_gate_reg && global_en_reg; // RULE20 RULE21

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_next;
   end

   assign periph_irq_req = irq_reg;

   // ==========================================================
   // Read channel
   logic       rvalid_reg;
   logic [7:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [7:0] rd_byte;
   pie_sel_t   rd_sel;

   assign s_axi_arready = !rvalid_reg;
   assign rd_sel        = decode_addr(s_axi_araddr);

   always_comb
   begin
      rd_byte = 8'h00;
      case (rd_sel)
         SEL_CTRL:
         begin
            rd_byte[PIE_GLOBAL_BIT] = global_en_reg;
            rd_byte[PIE_GATE_BIT]   = periph_gate_reg;
         end
         SEL_EN2:   rd_byte = en2_reg; // RULE18
         SEL_EN3:   rd_byte = en3_reg; // RULE18
         SEL_EN4:   rd_byte = en4_reg; // RULE18
         SEL_FLAG2: rd_byte = fl_grp[0];
         SEL_FLAG3: rd_byte = fl_grp[1];
         SEL_FLAG4: rd_byte = fl_grp[2];
         SEL_STAT:  rd_byte[PIE_STAT_REQ] = irq_reg;
         default:   rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 8'h00;
         rresp_reg  <= PIE_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_byte;
         rresp_reg  <= (rd_sel == SEL_NONE) ? PIE_RESP_SLV : PIE_RESP_OKAY;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = {24'h000000, rdata_reg};
   assign s_axi_rresp  = rresp_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_en2_write;
      wr_byte && wr_sel == SEL_EN2 |=> en2_reg == $past(wdata_reg);
   endproperty
   a_en2_write: assert property (p_en2_write) // RULE18
      else $error("enable2 did not take written byte");

   property p_flag_set;
      src_events.grp3[7] |=> fl_grp[1][7];
   endproperty
   a_flag_set: assert property (p_flag_set) // RULE19
      else $error("event did not set its flag");

   property p_gate_block;
      !periph_gate_reg |=> !periph_irq_req;
   endproperty
   a_gate_block: assert property (p_gate_block) // RULE20
      else $error("request passed a closed peripheral gate");

   property p_global_block;
      !global_en_reg |=> !periph_irq_req;
   endproperty
   a_global_block: assert property (p_global_block) // RULE21
      else $error("request passed a closed global enable");

   property p_req_source;
      periph_irq_req |-> $past(any_pend) && $past(global_en_reg) && $past(periph_gate_reg);
   endproperty
   a_req_source: assert property (p_req_source) // RULE22
      else $error("request raised without an enabled flag");

   property p_timer6;
      fl_grp[0][7] && en2_reg.timer6_match_irq_en && global_en_reg && periph_gate_reg
         |=> periph_irq_req;
   endproperty
   a_timer6: assert property (p_timer6) // RULE1
      else $error("timer 6 request not raised");

   property p_osc_fail;
      fl_grp[1][7] && en3_reg.oscillator_fail_irq_en && global_en_reg && periph_gate_reg
         |=> periph_irq_req;
   endproperty
   a_osc_fail: assert property (p_osc_fail) // RULE9
      else $error("oscillator fail request not raised");

   property p_capture1;
      fl_grp[2][0] && en4_reg.capture_unit1_irq_en && global_en_reg && periph_gate_reg
         |=> periph_irq_req;
   endproperty
   a_capture1: assert property (p_capture1) // RULE17
      else $error("capture unit 1 request not raised");

   property p_masked_quiet;
      (!(|{pend2, pend3, pend4}))[*2] |-> !periph_irq_req;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) // RULE22
      else $error("request raised with every source masked");

   property p_bresp_due;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[2:2] s_axi_bvalid;
   endproperty
   a_bresp_due: assert property (p_bresp_due)
      else $error("write response late");

endmodule : pie_enable_bank

// ==== pie_src_model.sv ====
// Partner model: peripheral event sources feeding the enable bank
module pie_src_model
   import pie_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Command from the bench
   input  wire logic        fire,
   input  wire pie_events_t pattern,
   // Events to the bank
   output pie_events_t      src_events
);
   // ==========================================================
   // Event pulses
   // Registered, so events move only on the bank's sampling edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_events <= '0;
      end
      else
      begin
         src_events <= fire ? pattern : '0;
      end
   end
endmodule : pie_src_model

// ==== pie_enable_bank_tb.sv ====
// Self-checking testbench of the peripheral interrupt enable bank
module pie_enable_bank_tb
   import pie_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Signals
   logic        aclk, aresetn, fire, periph_irq_req;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   pie_events_t pattern, src_events;
   int          seed = 80431;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [31:0] rq_d[$];
   logic [1:0]  rq_r[$];
   logic [1:0]  bq[$];
   // ==========================================================
   // Instances
   pie_enable_bank u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .src_events(src_events),
      .periph_irq_req(periph_irq_req));
   pie_src_model u_src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .pattern(pattern),
      .src_events(src_events));
   // ==========================================================
   // Clock and timeout
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   // ==========================================================
   // Checking
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_irq(input logic e);
      #1;
      chk({31'h0, periph_irq_req}, {31'h0, e}, "request");
   endtask : chk_irq
   // Notes from the driver are taken oldest first as answers appear
   always @(posedge aclk)
   begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      begin
         chk(s_axi_rdata, rq_d.pop_front(), "read data");
         chk({30'h0, s_axi_rresp}, {30'h0, rq_r.pop_front()}, "read resp");
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "write resp");
   end
   // ==========================================================
   // Bus master
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b1,
                     input logic [1:0] r = PIE_RESP_OKAY);
      logic done;
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h0, d};
      s_axi_wstrb   <= {3'h0, s};
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
         begin
            done = 1'b1;
            s_axi_bready <= 1'b0;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = PIE_RESP_OKAY);
      logic done;
      rq_d.push_back(d);
      rq_r.push_back(r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            done = 1'b1;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : rd
   task automatic pulse(input pie_events_t p);
      @(posedge aclk);
      fire    <= 1'b1;
      pattern <= p;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : pulse
   // ==========================================================
   // Scenarios
   // One source at a time: its own bit must be the only one that passes
   task automatic check_bit(input int g, input int b);
      logic [7:0] ea, fa, m;
      ea = PIE_OFF_EN2 + 8'(4 * g);
      fa = PIE_OFF_FLAG2 + 8'(4 * g);
      m = 8'h01 << b;
      wr(ea, ~m);
      pulse(pie_events_t'(24'(m) << (8 * (2 - g))));
      rd(fa, {24'h0, m});
      rd(PIE_OFF_STAT, 32'h0);
      wr(ea, m);
      repeat (2) @(posedge aclk);
      chk_irq(1'b1);
      rd(PIE_OFF_STAT, 32'h1);
      wr(fa, 8'h00);
      wr(ea, 8'h00);
      repeat (2) @(posedge aclk);
      chk_irq(1'b0);
   endtask : check_bit
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      logic [7:0]  en [3];
      logic [23:0] ev;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      fire = 1'b0;
      pattern = '0;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) rd(PIE_OFF_EN2 + 8'(4 * i), 32'h0);
      wr(PIE_OFF_CTRL, 8'hff);
      rd(PIE_OFF_CTRL, 32'hc0);
      for (int b = 7; b >= 0; b--)
      begin
         check_bit(0, b);
         check_bit(1, b);
         check_bit(2, b);
      end
      wr(PIE_OFF_EN2, 8'hff);
      wr(PIE_OFF_CTRL, 8'h80);
      pulse(pie_events_t'(24'hff0000));
      chk_irq(1'b0);
      wr(PIE_OFF_CTRL, 8'h40);
      repeat (2) @(posedge aclk);
      chk_irq(1'b0);
      wr(PIE_OFF_CTRL, 8'hc0);
      repeat (2) @(posedge aclk);
      chk_irq(1'b1);
      // Random enables against random events, several at once
      for (int i = 0; i < 6; i++)
      begin
         ev = 24'($random(seed));
         for (int k = 0; k < 3; k++)
         begin
            en[k] = 8'($random(seed));
            wr(PIE_OFF_FLAG2 + 8'(4 * k), 8'h00);
            wr(PIE_OFF_EN2 + 8'(4 * k), en[k]);
         end
         pulse(pie_events_t'(ev));
         chk_irq(|({en[0], en[1], en[2]} & ev));
         for (int k = 0; k < 3; k++)
         begin
            rd(PIE_OFF_FLAG2 + 8'(4 * k), {24'h0, ev[8 * (2 - k) +: 8]});
            rd(PIE_OFF_EN2 + 8'(4 * k), {24'h0, en[k]});
         end
      end
      // Masked write and unmapped place
      wr(PIE_OFF_EN2, 8'h5a);
      wr(PIE_OFF_EN2, 8'ha5, 1'b0);
      rd(PIE_OFF_EN2, 32'h5a);
      wr(8'h20, 8'h11, 1'b1, PIE_RESP_SLV);
      rd(8'h20, 32'h0, PIE_RESP_SLV);
      // Reset in mid-run clears every enable
      wr(PIE_OFF_EN3, 8'h3c);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) rd(PIE_OFF_EN2 + 8'(4 * i), 32'h0);
      chk_irq(1'b0);
      wrap_up();
   end
endmodule : pie_enable_bank_tb
